// ==== inc/clh_defs.svh ====
`ifndef CLH_DEFS_SVH
`define CLH_DEFS_SVH

// Memory sizes and scan positions per line.
`define CLH_DISP_DEPTH     80
`define CLH_GLYPH_DEPTH    64
`define CLH_POS_PER_LINE   8

// Display address map.
`define CLH_LINE_LEN       7'h28
`define CLH_ONE_RING       7'h50
`define CLH_LINE1_LAST     7'h27
`define CLH_LINE2_BASE     7'h40
`define CLH_LINE2_LAST     7'h67
`define CLH_ONE_LAST       7'h4f

// Command encodings.
`define CLH_OP_DISP_BIT    7
`define CLH_OP_GLYPH       2'h1
`define CLH_OP_SHIFT       4'h1
`define CLH_SHIFT_DISP_BIT 3
`define CLH_SHIFT_RIGHT_BIT 2

// User glyph selection.
`define CLH_USER_GLYPH_HI  4'h0

// Instruction execution time.
`define CLH_EXEC_NS        40000
`define CLH_CLK_NS         10
`define CLH_EXEC_CYC       ((`CLH_EXEC_NS + `CLH_CLK_NS - 1) / `CLH_CLK_NS)

`endif

// ==== inc/clh_pkg.sv ====
package clh_pkg;

   typedef enum logic [1:0] {
      clh_st_idle,
      clh_st_write,
      clh_st_fetch,
      clh_st_load
   } clh_state_t;

   typedef struct packed {
      logic       reg_select;
      logic       rd_wr;
      logic [7:0] host_data_bus;
   } clh_host_req_t;

   typedef struct packed {
      logic [6:0] disp_addr;
      logic [7:0] char_code;
      logic       user_glyph;
      logic [5:0] glyph_addr;
      logic       line;
      logic [2:0] pos;
   } clh_scan_t;

endpackage : clh_pkg

// ==== design/clh_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

module clh_mem #(
   parameter int DW    = 8,
   parameter int AW    = 7,
   parameter int DEPTH = 80
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          reset,
   // Host-side port
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata,
   // Scan-side port
   input  wire logic [AW-1:0] scan_addr,
   output logic      [DW-1:0] scan_rdata
);

   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] rdata_ff;
   logic [DW-1:0] scan_rdata_ff;

   always_ff @(posedge mclk) begin
      if (we && int'(addr) < DEPTH) begin
         mem[addr] <= wdata;
      end
   end

   // Two read ports so display refresh never waits on host traffic.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata_ff      <= '0;
         scan_rdata_ff <= '0;
      end else begin
         rdata_ff      <= (int'(addr) < DEPTH) ? mem[addr] : '0;
         scan_rdata_ff <= (int'(scan_addr) < DEPTH) ? mem[scan_addr] : '0;
      end
   end

   assign rdata      = rdata_ff;
   assign scan_rdata = scan_rdata_ff;

endmodule : clh_mem

`default_nettype wire

// ==== design/clh_host_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clh_defs.svh"

module clh_host_port #(
   parameter int EXEC_CYC     = `CLH_EXEC_CYC,
   parameter int POS_PER_LINE = `CLH_POS_PER_LINE
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  reset,
   // Host bus
   input  wire logic                  exec_strobe,
   input  wire clh_pkg::clh_host_req_t host_req,
   output logic [7:0]                 host_data_out,
   output logic                       host_data_oe,
   // Mode inputs
   input  wire logic                  line_mode,
   input  wire logic                  tall_font,
   // Display scan
   output clh_pkg::clh_scan_t         scan_out,
   output logic [7:0]                 scan_glyph_bits,
   output logic                       busy_indicator
);
   import clh_pkg::*;

   localparam int CW = $clog2(EXEC_CYC + 1);
   localparam int PW = $clog2(POS_PER_LINE);
   localparam logic [CW-1:0] CNT_LAST = CW'(EXEC_CYC - 1);
   localparam logic [PW-1:0] POS_LAST = PW'(POS_PER_LINE - 1);

   ////////////////////////////////////////////////////////////////////////
   // Address arithmetic.

   function automatic logic [6:0] ac_step(input logic [6:0] a,
                                          input logic two_line,
                                          input logic glyph);
      logic [6:0] r;
      r = a + 7'h01;
      if (glyph) begin
         r = {1'b0, r[5:0]};
      end else if (two_line && a == `CLH_LINE1_LAST) begin
         r = `CLH_LINE2_BASE;
      end else if (two_line && a == `CLH_LINE2_LAST) begin
         r = 7'h00;
      end else if (!two_line && a == `CLH_ONE_LAST) begin
         r = 7'h00;
      end
      return r;
   endfunction : ac_step

   // Maps a display address onto a dense memory index.
   function automatic logic [6:0] disp_index(input logic [6:0] a,
                                             input logic two_line);
      logic [6:0] r;
      r = a;
      if (two_line && a[6]) begin
         r = `CLH_LINE_LEN + {1'b0, a[5:0]};
      end
      return r;
   endfunction : disp_index

   function automatic logic [6:0] ring_len(input logic two_line);
      return two_line ? `CLH_LINE_LEN : `CLH_ONE_RING;
   endfunction : ring_len

   function automatic logic [6:0] wrap_add(input logic [6:0] a,
                                           input logic [6:0] b,
                                           input logic [6:0] ring);
      logic [7:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, ring}) begin
         s = s - {1'b0, ring};
      end
      if (s >= {1'b0, ring}) begin
         s = s - {1'b0, ring};
      end
      return s[6:0];
   endfunction : wrap_add

   ////////////////////////////////////////////////////////////////////////
   // Host strobe decode.

   logic             e_prev_ff;
   logic             take;
   logic             host_idle;
   logic             cmd_ok;
   logic             stat_rd;
   logic             dat_wr;
   logic             dat_rd;
   logic [7:0]       command_register_ff;
   logic [7:0]       data_register_ff;
   logic             busy_ff;
   logic [CW-1:0]    exec_cnt_ff;
   logic [6:0]       ac_ff;
   logic [6:0]       ac_snap_ff;
   logic [6:0]       ac_view;
   logic             sel_glyph_ff;
   clh_state_t       state_ff;
   logic [6:0]       shift_ff;
   logic             mode_q_ff;
   logic [7:0]       host_data_ff;
   logic             host_oe_ff;
   logic [7:0]       d_rdata;
   logic [7:0]       g_rdata;
   logic [7:0]       mem_rdata;
   logic [6:0]       host_addr;
   logic             is_disp_addr;
   logic             is_glyph_addr;
   logic             is_shift;

   assign take      = exec_strobe & ~e_prev_ff;
   assign host_idle = (state_ff == clh_st_idle);
   // Instructions are refused while the previous one still runs.
   assign cmd_ok  = take & ~host_req.reg_select & ~host_req.rd_wr
                    & ~busy_ff & host_idle;
   assign stat_rd = take & ~host_req.reg_select & host_req.rd_wr;
   assign dat_wr  = take & host_req.reg_select & ~host_req.rd_wr & host_idle;
   assign dat_rd  = take & host_req.reg_select & host_req.rd_wr & host_idle;

   assign is_disp_addr  = host_req.host_data_bus[`CLH_OP_DISP_BIT];
   assign is_glyph_addr = (host_req.host_data_bus[7:6] == `CLH_OP_GLYPH);
   assign is_shift      = (host_req.host_data_bus[7:4] == `CLH_OP_SHIFT)
                          & host_req.host_data_bus[`CLH_SHIFT_DISP_BIT];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         e_prev_ff <= 1'b0;
      end else begin
         e_prev_ff <= exec_strobe;
      end
   end

   // Command register takes only accepted instruction writes.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         command_register_ff <= 8'h00;
      end else if (cmd_ok) begin
         command_register_ff <= host_req.host_data_bus;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction execution and busy indicator.

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         busy_ff     <= 1'b0;
         exec_cnt_ff <= '0;
      end else if (cmd_ok) begin
         busy_ff     <= 1'b1;
         exec_cnt_ff <= '0;
      end else if (busy_ff) begin
         if (exec_cnt_ff == CNT_LAST) begin
            busy_ff <= 1'b0;
         end else begin
            exec_cnt_ff <= exec_cnt_ff + CW'(1);
         end
      end
   end

   // Snapshot keeps the pre-instruction address visible while busy.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ac_snap_ff <= 7'h00;
      end else if (cmd_ok) begin
         ac_snap_ff <= ac_ff;
      end
   end

   assign ac_view = busy_ff ? ac_snap_ff : ac_ff;

   ////////////////////////////////////////////////////////////////////////
   // Address counter shared by both memories.

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ac_ff        <= 7'h00;
         sel_glyph_ff <= 1'b0;
      end else if (cmd_ok && is_disp_addr) begin
         ac_ff        <= host_req.host_data_bus[6:0];
         sel_glyph_ff <= 1'b0;
      end else if (cmd_ok && is_glyph_addr) begin
         ac_ff        <= {1'b0, host_req.host_data_bus[5:0]};
         sel_glyph_ff <= 1'b1;
      end else if (state_ff == clh_st_write || dat_rd) begin
         ac_ff <= ac_step(ac_ff, line_mode, sel_glyph_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencer between data register and memories.

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_ff <= clh_st_idle;
      end else begin
         unique case (state_ff)
            clh_st_idle: begin
               if (dat_wr) begin
                  state_ff <= clh_st_write;
               end else if (dat_rd) begin
                  state_ff <= clh_st_fetch;
               end else if (cmd_ok && (is_disp_addr || is_glyph_addr)) begin
                  state_ff <= clh_st_fetch;
               end
            end
            clh_st_write: begin
               state_ff <= clh_st_idle;
            end
            clh_st_fetch: begin
               state_ff <= clh_st_load;
            end
            clh_st_load: begin
               state_ff <= clh_st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         data_register_ff <= 8'h00;
      end else if (dat_wr) begin
         data_register_ff <= host_req.host_data_bus;
      end else if (state_ff == clh_st_load) begin
         data_register_ff <= mem_rdata;
      end
   end

   assign host_addr = sel_glyph_ff ? {1'b0, ac_ff[5:0]}
                                   : disp_index(ac_ff, line_mode);
   assign mem_rdata = sel_glyph_ff ? g_rdata : d_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Host read data.

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         host_data_ff <= 8'h00;
         host_oe_ff   <= 1'b0;
      end else begin
         host_oe_ff <= exec_strobe & host_req.rd_wr;
         if (stat_rd) begin
            host_data_ff <= {busy_ff, ac_view};
         end else if (dat_rd) begin
            host_data_ff <= data_register_ff;
         end
      end
   end

   assign host_data_out  = host_data_ff;
   assign host_data_oe   = host_oe_ff;
   assign busy_indicator = busy_ff;

   ////////////////////////////////////////////////////////////////////////
   // Display shift.

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         shift_ff  <= 7'h00;
         mode_q_ff <= 1'b0;
      end else begin
         mode_q_ff <= line_mode;
         if (line_mode != mode_q_ff) begin
            shift_ff <= 7'h00;
         end else if (cmd_ok && is_shift) begin
            // One offset for both lines, so they move together.
            if (host_req.host_data_bus[`CLH_SHIFT_RIGHT_BIT]) begin
               shift_ff <= (shift_ff == 7'h00)
                           ? ring_len(line_mode) - 7'h01
                           : shift_ff - 7'h01;
            end else begin
               shift_ff <= (shift_ff == ring_len(line_mode) - 7'h01)
                           ? 7'h00 : shift_ff + 7'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Display scan on its own memory port.

   logic [PW-1:0] pos_ff;
   logic          line_ff;
   logic [3:0]    row_ff;
   logic [6:0]    scan_addr_c;
   logic [6:0]    s1_addr_ff;
   logic          s1_line_ff;
   logic [PW-1:0] s1_pos_ff;
   logic [3:0]    s1_row_ff;
   logic [7:0]    d_scan_rdata;
   clh_scan_t     scan_ff;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pos_ff  <= '0;
         line_ff <= 1'b0;
         row_ff  <= 4'h0;
      end else if (pos_ff == POS_LAST) begin
         pos_ff <= '0;
         if (line_ff || !line_mode) begin
            line_ff <= 1'b0;
            row_ff  <= row_ff + 4'h1;
         end else begin
            line_ff <= 1'b1;
         end
      end else begin
         pos_ff <= pos_ff + PW'(1);
      end
   end

   assign scan_addr_c = (line_ff ? `CLH_LINE2_BASE : 7'h00)
                        + wrap_add(7'(pos_ff), shift_ff,
                                   ring_len(line_mode));

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s1_addr_ff <= 7'h00;
         s1_line_ff <= 1'b0;
         s1_pos_ff  <= '0;
         s1_row_ff  <= 4'h0;
         scan_ff    <= '0;
      end else begin
         s1_addr_ff <= scan_addr_c;
         s1_line_ff <= line_ff;
         s1_pos_ff  <= pos_ff;
         s1_row_ff  <= row_ff;
         scan_ff.disp_addr  <= s1_addr_ff;
         scan_ff.char_code  <= d_scan_rdata;
         scan_ff.user_glyph <= (d_scan_rdata[7:4] == `CLH_USER_GLYPH_HI);
         scan_ff.line       <= s1_line_ff;
         scan_ff.pos        <= 3'(s1_pos_ff);
         if (tall_font) begin
            scan_ff.glyph_addr <= {d_scan_rdata[2:1], s1_row_ff};
         end else begin
            scan_ff.glyph_addr <= {d_scan_rdata[2:0], s1_row_ff[2:0]};
         end
      end
   end

   assign scan_out = scan_ff;

   ////////////////////////////////////////////////////////////////////////
   // Memories.

   clh_mem #(
      .DW    (8),
      .AW    (7),
      .DEPTH (`CLH_DISP_DEPTH)
   ) u_disp_mem (
      .mclk       (mclk),
      .reset      (reset),
      .we         (state_ff == clh_st_write && !sel_glyph_ff),
      .addr       (host_addr),
      .wdata      (data_register_ff),
      .rdata      (d_rdata),
      .scan_addr  (disp_index(scan_addr_c, line_mode)),
      .scan_rdata (d_scan_rdata)
   );

   clh_mem #(
      .DW    (8),
      .AW    (6),
      .DEPTH (`CLH_GLYPH_DEPTH)
   ) u_glyph_mem (
      .mclk       (mclk),
      .reset      (reset),
      .we         (state_ff == clh_st_write && sel_glyph_ff),
      .addr       (host_addr[5:0]),
      .wdata      (data_register_ff),
      .rdata      (g_rdata),
      .scan_addr  (scan_ff.glyph_addr),
      .scan_rdata (scan_glyph_bits)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_cmd_busy;
      @(posedge mclk) disable iff (reset)
      cmd_ok |=> busy_ff && command_register_ff == $past(host_req.host_data_bus);
   endproperty
   a_cmd_busy: assert property (p_cmd_busy)
      else $error("accepted instruction did not raise busy");

   property p_busy_block;
      @(posedge mclk) disable iff (reset)
      busy_ff && take && !host_req.reg_select && !host_req.rd_wr
      |=> $stable(command_register_ff);
   endproperty
   a_busy_block: assert property (p_busy_block)
      else $error("instruction taken while busy");

   property p_busy_len;
      @(posedge mclk) disable iff (reset)
      busy_ff |-> exec_cnt_ff <= CNT_LAST;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy counter overran");

   property p_status;
      @(posedge mclk) disable iff (reset)
      stat_rd |=> host_data_out == {$past(busy_ff), $past(ac_view)};
   endproperty
   a_status: assert property (p_status)
      else $error("status read shows wrong value");

   property p_snap;
      @(posedge mclk) disable iff (reset)
      cmd_ok |=> busy_ff && ac_view == $past(ac_ff);
   endproperty
   a_snap: assert property (p_snap)
      else $error("status address not the pre-instruction value");

   property p_data_read;
      @(posedge mclk) disable iff (reset)
      dat_rd |=> host_data_out == $past(data_register_ff) ##1
                 state_ff == clh_st_load;
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read or prefetch wrong");

   property p_write;
      @(posedge mclk) disable iff (reset)
      dat_wr |=> state_ff == clh_st_write
                 && data_register_ff == $past(host_req.host_data_bus);
   endproperty
   a_write: assert property (p_write)
      else $error("data write did not reach memory stage");

   property p_fetch;
      @(posedge mclk) disable iff (reset)
      cmd_ok && (is_disp_addr || is_glyph_addr) |=> ##1
      state_ff == clh_st_load;
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("address write did not fetch");

   property p_two_line_step;
      @(posedge mclk) disable iff (reset)
      state_ff == clh_st_write && line_mode && !sel_glyph_ff
      && ac_ff == `CLH_LINE1_LAST |=> ac_ff == `CLH_LINE2_BASE;
   endproperty
   a_two_line_step: assert property (p_two_line_step)
      else $error("counter did not step from 27 to 40");

   property p_one_line_wrap;
      @(posedge mclk) disable iff (reset)
      state_ff == clh_st_write && !line_mode && !sel_glyph_ff
      && ac_ff == `CLH_ONE_LAST |=> ac_ff == 7'h00;
   endproperty
   a_one_line_wrap: assert property (p_one_line_wrap)
      else $error("counter did not wrap from 4f to 00");

   property p_shift_range;
      @(posedge mclk) disable iff (reset)
      shift_ff < ring_len(mode_q_ff);
   endproperty
   a_shift_range: assert property (p_shift_range)
      else $error("shift offset left its ring");

   c_write: cover property (@(posedge mclk) disable iff (reset)
      dat_wr ##1 state_ff == clh_st_write);
   c_read: cover property (@(posedge mclk) disable iff (reset)
      dat_rd ##[1:3] state_ff == clh_st_load);
   c_refused: cover property (@(posedge mclk) disable iff (reset)
      busy_ff && take && !host_req.reg_select && !host_req.rd_wr);
   c_shift: cover property (@(posedge mclk) disable iff (reset)
      cmd_ok && is_shift && line_mode);

endmodule : clh_host_port

`default_nettype wire

// ==== verif/clh_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module clh_host_model (
   // Clock
   input  wire logic                   mclk,
   // Host bus
   output var  logic                   exec_strobe,
   output var  clh_pkg::clh_host_req_t host_req,
   input  wire logic [7:0]             host_data_out
);
   import clh_pkg::*;

   initial begin
      exec_strobe = 1'b0;
      host_req    = '0;
   end

   // One strobed access, spaced five cycles from the next one.
   task automatic cycle(input logic rs, input logic rw,
                        input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      #1;
      host_req.reg_select    = rs;
      host_req.rd_wr         = rw;
      host_req.host_data_bus = rw ? ~host_req.host_data_bus : d;
      exec_strobe            = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      q           = host_data_out;
      exec_strobe = 1'b0;
      repeat (2) @(posedge mclk);
   endtask : cycle

   task automatic wait_ready(output logic [7:0] st);
      int n;
      n = 0;
      do begin
         cycle(1'b0, 1'b1, 8'h00, st);
         n++;
      end while (st[7] !== 1'b0 && n < 50);
   endtask : wait_ready

   task automatic instr(input logic [7:0] c);
      logic [7:0] st;
      wait_ready(st);
      cycle(1'b0, 1'b0, c, st);
   endtask : instr
endmodule : clh_host_model

`default_nettype wire

// ==== verif/char_lcd_host_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module char_lcd_host_port_tb;
   import clh_pkg::*;

   logic          mclk;
   logic          reset;
   logic          exec_strobe;
   logic          line_mode;
   logic          tall_font;
   logic          host_data_oe;
   logic          busy_indicator;
   logic [7:0]    host_data_out;
   clh_host_req_t host_req;
   int            err_total;
   int            comparisons;
   int            cyc;
   logic [31:0]   rng;
   logic [7:0]    q;
   logic [7:0]    d [0:2];
   logic [6:0]    a;
   logic [6:0]    st;
   logic [1:0]    m;
   clh_scan_t     scan;
   logic [7:0]    scan_glyph_bits;

   // Long enough that an instruction ten cycles later is still refused.
   clh_host_port #(.EXEC_CYC(16)) u_clh_host_port (
      .mclk(mclk), .reset(reset), .exec_strobe(exec_strobe),
      .host_req(host_req), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe), .line_mode(line_mode),
      .tall_font(tall_font), .scan_out(scan),
      .scan_glyph_bits(scan_glyph_bits),
      .busy_indicator(busy_indicator));

   clh_host_model u_clh_host_model (
      .mclk(mclk), .exec_strobe(exec_strobe), .host_req(host_req),
      .host_data_out(host_data_out));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   function automatic logic [7:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : xs

   // Mode 0 one line, 1 two lines, 2 glyph memory.
   function automatic logic [6:0] next_addr(logic [6:0] x, logic [1:0] md);
      if (md == 2'd2) return {1'b0, x[5:0] + 6'h01};
      if (md == 2'd1 && x == 7'h27) return 7'h40;
      if (md == 2'd1 && x == 7'h67) return 7'h00;
      if (md == 2'd0 && x == 7'h4f) return 7'h00;
      return x + 7'h01;
   endfunction : next_addr

   task automatic cmp8(string nm, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp8

   // Waits for a scan slot, then checks what the display shows there.
   task automatic scan_chk(input logic [6:0] ad, input logic [5:0] ga,
                           input logic gm, input logic [2:0] ps,
                           input logic [7:0] e);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      while ((scan.disp_addr !== ad || (gm && scan.glyph_addr !== ga))
             && n < 300) begin
         @(posedge mclk);
         #1;
         n++;
      end
      cmp8("scan addr", {1'b0, ad}, {1'b0, scan.disp_addr});
      cmp8("scan pos", {5'h00, ps}, {5'h00, scan.pos});
      if (gm) begin
         cmp8("glyph addr", {2'h0, ga}, {2'h0, scan.glyph_addr});
         @(posedge mclk);
         #1;
         cmp8("glyph bits", e, scan_glyph_bits);
      end else begin
         cmp8("scan code", e, scan.char_code);
      end
   endtask : scan_chk

   task automatic test_done();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         test_done();
      end
   end

   initial begin
      reset = 1'b1;
      line_mode = 1'b0;
      tall_font = 1'b0;
      rng = 32'd96;
      err_total = 0;
      comparisons = 0;
      cyc = 0;
      repeat (4) @(posedge mclk);
      #1 reset = 1'b0;
      @(posedge mclk);
      #1;
      cmp8("reset outputs", 8'h00, host_data_out);
      cmp8("reset flags", 8'h00,
           {6'h00, busy_indicator, host_data_oe});
      // A second instruction while busy must leave no trace.
      u_clh_host_model.instr(8'h85);
      u_clh_host_model.cycle(1'b0, 1'b1, 8'h00, q);
      cmp8("status busy", 8'h80, q);
      u_clh_host_model.cycle(1'b0, 1'b0, 8'hb0, q);
      u_clh_host_model.wait_ready(q);
      cmp8("status idle", 8'h05, q);
      // Boundary rows, a glyph row and a random row.
      for (int i = 0; i < 5; i++) begin
         m = (i < 2) ? 2'd1 : (i == 2) ? 2'd0 : (i == 3) ? 2'd2 : 2'd1;
         st = (i == 0) ? 7'h26 : (i == 1) ? 7'h66 : (i == 2) ? 7'h4e :
              (i == 3) ? 7'h3e : 7'(xs() % 8'd37);
         #1 line_mode = m[0];
         a = st;
         u_clh_host_model.instr((m == 2'd2) ? {2'b01, st[5:0]}
                                            : {1'b1, st});
         for (int k = 0; k < 3; k++) begin
            d[k] = xs();
            u_clh_host_model.cycle(1'b1, 1'b0, d[k], q);
            a = next_addr(a, m);
         end
         u_clh_host_model.wait_ready(q);
         cmp8("counter", {1'b0, a}, q);
         if (i == 1) begin
            // Right shift puts 67 at the head of line two; left undoes it.
            scan_chk(7'h00, 6'h00, 1'b0, 3'd0, d[2]);
            u_clh_host_model.instr(8'h1c);
            scan_chk(7'h67, 6'h00, 1'b0, 3'd0, d[1]);
            u_clh_host_model.instr(8'h18);
            scan_chk(7'h00, 6'h00, 1'b0, 3'd0, d[2]);
         end
         if (i == 3) begin
            // Code 0f selects user glyph 7 (glyph 3 with tall_font), as bit 3 is ignored.
            u_clh_host_model.instr(8'h80);
            u_clh_host_model.cycle(1'b1, 1'b0, 8'h0f, q);
            scan_chk(7'h00, 6'h3e, 1'b1, 3'd0, d[0]);
            tall_font = 1'b1;
            scan_chk(7'h00, 6'h3e, 1'b1, 3'd0, d[0]);
            tall_font = 1'b0;
         end
         u_clh_host_model.instr((m == 2'd2) ? {2'b01, st[5:0]}
                                            : {1'b1, st});
         for (int k = 0; k < 3; k++) begin
            u_clh_host_model.cycle(1'b1, 1'b1, 8'h00, q);
            cmp8("data read", d[k], q);
         end
      end
      test_done();
   end
endmodule : char_lcd_host_port_tb

`default_nettype wire
